// ==== hdl/dual_slave_spi_fifo_datapath.v ====
// Dual slave SPI front end with FIFO and bit serial shift register
// Operation
// R1: MISO driven only while a select is low
// R2: IRQ pins released in standby/FS continuous
// R3: Two-bit mode: serial, buffered, packet
// R4: Continuous mode passes bits over data pin
// R5: Buffered mode stores every byte in FIFO
// R6: Packet mode adds and strips preamble, sync
// R7: Config select has priority over data select
// R8: Config always served; data port not continuous
// R9: Config writes take effect at select rise
// R10: Write burst alternates address and value
// R11: Read burst alternates address and value
// R12: Written byte pushed at data select rise
// R13: Master raises data select between bytes
// R14: FIFO status shown on interrupt pins
// R15: FIFO entries are whole bytes
// R16: Transmit shifts FIFO bytes out MSB first
// R17: Receive collects bits, writes each byte
// R18: FIFO depth selectable 16, 32, 48, 64
// R19: FIFO cleared on listed mode changes
// R20: Overrun flag, cleared by one, empties FIFO
// R21: SPI MSB first, sample rise, shift fall
// R22: Empty FIFO read returns zero, no change
`timescale 1ns/1ps
`default_nettype none
`include "dual_slave_spi_fifo_consts.vh"
module dual_slave_spi_fifo_datapath #(
    parameter CFG_REGS = 4,
    parameter FIFO_MAX = 64,
    parameter BIT_DIV = `BIT_CYC
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // SPI pins
    input wire sck,
    input wire mosi,
    input wire cfg_port_select_n,
    input wire fifo_port_select_n,
    output reg miso,
    output reg miso_oe,
    // Data pin
    input wire data_in,
    output reg data_out,
    output reg data_oe,
    // Interrupt pins
    output reg irq0,
    output reg irq0_oe,
    output reg irq1,
    output reg irq1_oe,
    // Modem side
    input wire demod_bit,
    output reg mod_bit
);
    // ==================================================
    // Pin synchronisers
    reg [4:0] s1_reg;
    reg [4:0] s2_reg;
    reg [4:0] s3_reg;
    reg [4:0] filt_reg;
    reg [4:0] prev_reg;
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            s1_reg <= `PIN_RST;
            s2_reg <= `PIN_RST;
            s3_reg <= `PIN_RST;
            filt_reg <= `PIN_RST;
            prev_reg <= `PIN_RST;
        end
        else
        begin
            s1_reg <= {data_in, fifo_port_select_n, cfg_port_select_n,
                       mosi, sck};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Accept a change once second and third stages agree
            filt_reg <= (filt_reg & (s2_reg ^ s3_reg)) |
                        (s3_reg & ~(s2_reg ^ s3_reg));
            prev_reg <= filt_reg;
        end
    end
    wire sck_rise = filt_reg[0] & ~prev_reg[0];
    wire sck_fall = ~filt_reg[0] & prev_reg[0];
    wire cfg_sel = ~filt_reg[2];
    wire cfg_fall = cfg_sel & prev_reg[2];
    wire cfg_rise = filt_reg[2] & ~prev_reg[2];
    wire dat_sel = filt_reg[2] & ~filt_reg[3]; // R7
    wire dat_fall = dat_sel & prev_reg[3];
    wire dat_rise = filt_reg[3] & ~prev_reg[3] & filt_reg[2];
    // ==================================================
    // Configuration registers
    reg [7:0] cfg_reg [0:CFG_REGS-1];
    reg [7:0] shad_reg [0:CFG_REGS-1];
    wire [2:0] chip_mode = cfg_reg[0][`CHIP_MODE_HI:`CHIP_MODE_LO];
    wire [1:0] data_path_mode = cfg_reg[0][`DPM_HI:`DPM_LO];
    wire [1:0] fifo_depth_sel = cfg_reg[0][`DEPTH_HI:`DEPTH_LO];
    wire [7:0] sync_word = cfg_reg[`REG_SYNC];
    wire is_cont = (data_path_mode == `DPM_CONT); // R3
    wire is_pkt = data_path_mode[1]; // R3
    wire ovr_clr = cfg_rise & shad_reg[`REG_STAT][`OVR_CLR_BIT];
    // ==================================================
    // FIFO state
    reg [7:0] fifo_mem [0:FIFO_MAX-1];
    reg [5:0] wp_reg;
    reg [5:0] rp_reg;
    reg [6:0] cnt_reg;
    reg ovr_reg;
    reg spi_push_reg;
    reg spi_pop_reg;
    reg ser_push_reg;
    reg ser_pop_reg;
    reg [7:0] ser_byte_reg;
    reg [2:0] prev_mode_reg;
    reg dir_rx_reg;
    wire [6:0] depth = {fifo_depth_sel + 3'h1, 4'h0}; // R18
    wire full = (cnt_reg >= depth);
    wire empty = (cnt_reg == 7'h00);
    wire [7:0] head = fifo_mem[rp_reg];
    // ==================================================
    // SPI slave engine shared by both ports
    reg [2:0] bcnt_reg;
    reg [7:0] rx_sh_reg;
    reg [7:0] tx_sh_reg;
    reg addr_phase_reg;
    reg [7:0] addr_reg;
    reg got_byte_reg;
    wire [7:0] rx_byte = {rx_sh_reg[6:0], filt_reg[1]};
    wire [6:0] rd_addr = rx_byte[6:0];
    wire [7:0] stat_val = {5'h00, full, ~empty, ovr_reg};
    wire [7:0] rd_val = (rd_addr == `REG_STAT) ? stat_val :
        (rd_addr < CFG_REGS) ? cfg_reg[rd_addr[1:0]] : `ZERO_RST;
    wire dat_ok = ~is_cont; // R8
    integer i;
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            bcnt_reg <= 3'h0;
            rx_sh_reg <= `ZERO_RST;
            tx_sh_reg <= `ZERO_RST;
            addr_phase_reg <= 1'b1;
            addr_reg <= `ZERO_RST;
            got_byte_reg <= 1'b0;
            spi_push_reg <= 1'b0;
            spi_pop_reg <= 1'b0;
            miso <= 1'b0;
            miso_oe <= 1'b0;
            for (i = 0; i < CFG_REGS; i = i + 1)
            begin
                cfg_reg[i] <= `ZERO_RST;
                shad_reg[i] <= `ZERO_RST;
            end
            cfg_reg[`REG_MODE] <= `MODE_RST;
            shad_reg[`REG_MODE] <= `MODE_RST;
            cfg_reg[`REG_SYNC] <= `SYNC_RST;
            shad_reg[`REG_SYNC] <= `SYNC_RST;
        end
        else
        begin
            spi_push_reg <= 1'b0;
            spi_pop_reg <= 1'b0;
            miso <= tx_sh_reg[7];
            miso_oe <= cfg_sel | dat_sel; // R1
            if (cfg_fall | dat_fall)
            begin
                bcnt_reg <= 3'h0;
                addr_phase_reg <= 1'b1;
                got_byte_reg <= 1'b0;
                tx_sh_reg <= `ZERO_RST;
                // One pop per data select, empty gives zero
                if (dat_fall & dat_ok & dir_rx_reg & ~empty) // R13
                begin
                    tx_sh_reg <= head;
                    spi_pop_reg <= 1'b1;
                end
            end
            else if (sck_rise & (cfg_sel | dat_sel)) // R21
            begin
                rx_sh_reg <= rx_byte;
                bcnt_reg <= bcnt_reg + 3'h1;
                if (bcnt_reg == 3'h7)
                begin
                    if (dat_sel)
                        got_byte_reg <= 1'b1;
                    else if (addr_phase_reg) // R10
                    begin
                        addr_reg <= rx_byte;
                        addr_phase_reg <= 1'b0;
                        if (rx_byte[`ADDR_READ_BIT]) // R11
                            tx_sh_reg <= rd_val;
                    end
                    else
                    begin
                        addr_phase_reg <= 1'b1; // R11
                        if (~addr_reg[`ADDR_READ_BIT] &&
                            addr_reg[6:0] < CFG_REGS)
                            shad_reg[addr_reg[1:0]] <= rx_byte; // R10
                    end
                end
            end
            else if (sck_fall & (bcnt_reg != 3'h0))
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0}; // R21
            if (cfg_rise)
            begin
                for (i = 0; i < CFG_REGS; i = i + 1)
                    cfg_reg[i] <= shad_reg[i]; // R9
                shad_reg[`REG_STAT] <= `ZERO_RST; // R20
            end
            if (dat_rise & got_byte_reg & dat_ok & ~dir_rx_reg)
                spi_push_reg <= 1'b1; // R12
        end
    end
    // ==================================================
    // FIFO
    wire push = spi_push_reg | ser_push_reg;
    wire pop = spi_pop_reg | ser_pop_reg;
    wire [7:0] push_data = ser_push_reg ? ser_byte_reg : rx_sh_reg;
    wire mode_chg = (chip_mode != prev_mode_reg);
    wire mode_clr = mode_chg & (
        (chip_mode == `CHIP_SLEEP) |
        (chip_mode == `CHIP_RX) |
        (chip_mode == `CHIP_TX & prev_mode_reg == `CHIP_RX) |
        (chip_mode == `CHIP_TX & prev_mode_reg == `CHIP_STBY &
         ~is_pkt)); // R19
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            wp_reg <= 6'h00;
            rp_reg <= 6'h00;
            cnt_reg <= 7'h00;
            ovr_reg <= 1'b0;
            prev_mode_reg <= `CHIP_STBY;
            dir_rx_reg <= 1'b0;
        end
        else
        begin
            prev_mode_reg <= chip_mode;
            if (chip_mode == `CHIP_RX)
                dir_rx_reg <= 1'b1;
            else if (chip_mode == `CHIP_TX)
                dir_rx_reg <= 1'b0;
            if (push & full)
                ovr_reg <= 1'b1; // R20
            else if (ovr_clr)
                ovr_reg <= 1'b0; // R20
            if (mode_clr | ovr_clr) // R19
            begin
                wp_reg <= 6'h00;
                rp_reg <= 6'h00;
                cnt_reg <= 7'h00;
            end
            else
            begin
                if (push & ~full) // R5
                begin
                    fifo_mem[wp_reg] <= push_data; // R15
                    wp_reg <= wp_reg + 6'h01;
                end
                if (pop & ~empty) // R22
                    rp_reg <= rp_reg + 6'h01;
                if ((push & ~full) & ~(pop & ~empty))
                    cnt_reg <= cnt_reg + 7'h01;
                else if (~(push & ~full) & (pop & ~empty))
                    cnt_reg <= cnt_reg - 7'h01;
            end
        end
    end
    // ==================================================
    // Bit rate timer and shift register
    reg [15:0] bt_reg;
    reg [7:0] serdes_shift_reg;
    reg [2:0] bits_left_reg;
    reg [2:0] bitno_reg;
    reg [2:0] pre_cnt_reg;
    reg locked_reg;
    wire tick = (bt_reg == BIT_DIV - 1);
    wire dclk = (bt_reg < BIT_DIV / 2);
    wire [7:0] rx_next = {serdes_shift_reg[6:0], demod_bit};
    wire [7:0] pre_byte = (pre_cnt_reg < `PRE_BYTES) ? `PREAMBLE :
                          sync_word;
    wire tx_on = (chip_mode == `CHIP_TX) & ~is_cont;
    wire rx_on = (chip_mode == `CHIP_RX) & ~is_cont;
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            bt_reg <= 16'h0000;
            serdes_shift_reg <= `ZERO_RST;
            bits_left_reg <= 3'h0;
            bitno_reg <= 3'h0;
            pre_cnt_reg <= 3'h0;
            locked_reg <= 1'b0;
            ser_push_reg <= 1'b0;
            ser_pop_reg <= 1'b0;
            ser_byte_reg <= `ZERO_RST;
            mod_bit <= 1'b0;
        end
        else
        begin
            ser_push_reg <= 1'b0;
            ser_pop_reg <= 1'b0;
            bt_reg <= tick ? 16'h0000 : bt_reg + 16'h0001;
            if (~tx_on & ~rx_on)
            begin
                bits_left_reg <= 3'h0;
                bitno_reg <= 3'h0;
                pre_cnt_reg <= 3'h0;
                locked_reg <= 1'b0;
                if (is_cont & chip_mode == `CHIP_TX)
                    mod_bit <= filt_reg[4]; // R4
            end
            else if (tick & tx_on)
            begin
                if (bits_left_reg != 3'h0) // R16
                begin
                    serdes_shift_reg <= {serdes_shift_reg[6:0], 1'b0};
                    mod_bit <= serdes_shift_reg[6];
                    bits_left_reg <= bits_left_reg - 3'h1;
                end
                else if (is_pkt & pre_cnt_reg != `PRE_DONE) // R6
                begin
                    serdes_shift_reg <= pre_byte;
                    mod_bit <= pre_byte[7];
                    bits_left_reg <= 3'h7;
                    pre_cnt_reg <= pre_cnt_reg + 3'h1;
                end
                else if (~empty) // R16
                begin
                    serdes_shift_reg <= head;
                    mod_bit <= head[7];
                    bits_left_reg <= 3'h7;
                    ser_pop_reg <= 1'b1;
                end
            end
            else if (tick & rx_on) // R17
            begin
                serdes_shift_reg <= rx_next;
                if (is_pkt & ~locked_reg)
                begin
                    bitno_reg <= 3'h0;
                    if (rx_next == sync_word)
                        locked_reg <= 1'b1; // R6
                end
                else
                begin
                    bitno_reg <= bitno_reg + 3'h1;
                    if (bitno_reg == 3'h7)
                    begin
                        ser_push_reg <= 1'b1; // R17
                        ser_byte_reg <= rx_next;
                    end
                end
            end
        end
    end
    // ==================================================
    // Data and interrupt pins
    wire idle_mode = (chip_mode == `CHIP_STBY) | (chip_mode == `CHIP_FS);
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            data_out <= 1'b0;
            data_oe <= 1'b0;
            irq0 <= 1'b0;
            irq0_oe <= 1'b0;
            irq1 <= 1'b0;
            irq1_oe <= 1'b0;
        end
        else
        begin
            data_oe <= (chip_mode == `CHIP_RX);
            data_out <= is_cont & demod_bit; // R4
            irq0 <= ~is_cont & ~empty; // R14
            irq1 <= is_cont ? dclk : full; // R14
            irq0_oe <= (chip_mode != `CHIP_SLEEP) &
                       ~(idle_mode & is_cont); // R2
            irq1_oe <= (chip_mode != `CHIP_SLEEP) &
                       ~(idle_mode & is_cont); // R2
        end
    end
endmodule
`default_nettype wire

// ==== hdl/dual_slave_spi_fifo_consts.vh ====
// Constants for the dual slave SPI FIFO datapath
`ifndef DUAL_SLAVE_SPI_FIFO_CONSTS_VH
`define DUAL_SLAVE_SPI_FIFO_CONSTS_VH
// Configuration register indices
`define REG_MODE 2'h0
`define REG_STAT 2'h1
`define REG_SYNC 2'h2
// Mode register fields, status overrun clear bit, address byte read bit
`define CHIP_MODE_HI 7
`define CHIP_MODE_LO 5
`define DPM_HI 4
`define DPM_LO 3
`define DEPTH_HI 2
`define DEPTH_LO 1
`define OVR_CLR_BIT 0
`define ADDR_READ_BIT 7
// Reset values
`define MODE_RST 8'h2e
`define SYNC_RST 8'h69
`define ZERO_RST 8'h00
`define PIN_RST 5'h0c
// Chip modes
`define CHIP_SLEEP 3'h0
`define CHIP_STBY 3'h1
`define CHIP_FS 3'h2
`define CHIP_RX 3'h3
`define CHIP_TX 3'h4
// Data path modes
`define DPM_CONT 2'h0
`define DPM_BUF 2'h1
// Packet framing
`define PREAMBLE 8'h55
`define PRE_BYTES 3'h3
`define PRE_DONE 3'h4
// Timing
`define CLK_PERIOD_NS 50
`define BIT_TIME_NS 5000
`define BIT_CYC (`BIT_TIME_NS / `CLK_PERIOD_NS)
`endif

// ==== sim/spi_master_model.sv ====
// SPI master model driving both slave ports of the datapath
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    // Clock
    input wire logic ref_clk,
    // SPI pins
    output logic sck,
    output logic mosi,
    output logic cfg_port_select_n,
    output logic fifo_port_select_n,
    input wire logic miso
);
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        cfg_port_select_n = 1'b1;
        fifo_port_select_n = 1'b1;
    end
    // ========================================
    // Select the ports in sel ({config, data}) and let the syncs settle
    task automatic sel_on(input logic [1:0] sel);
        @(negedge ref_clk);
        cfg_port_select_n = !sel[1];
        fifo_port_select_n = !sel[0];
        repeat (8) @(negedge ref_clk);
    endtask
    // Deselect; the gap keeps data port bytes one per select
    task automatic close;
        cfg_port_select_n = 1'b1;
        fifo_port_select_n = 1'b1;
        repeat (16) @(negedge ref_clk);
    endtask
    // One byte, 400 ns per bit; miso taken as the high phase ends
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            mosi = tx[i];
            repeat (4) @(negedge ref_clk);
            sck = 1'b1;
            repeat (4) @(negedge ref_clk);
            rx[i] = miso;
            sck = 1'b0;
        end
        mosi = !tx[0];
    endtask
endmodule
`default_nettype wire

// ==== sim/dual_slave_spi_fifo_datapath_sva.sv ====
// Pin-level assertions for the dual slave SPI FIFO datapath
`timescale 1ns/1ps
`default_nettype none
module dual_slave_spi_fifo_datapath_sva (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Watched pins
    input wire cfg_port_select_n,
    input wire fifo_port_select_n,
    input wire miso_oe,
    input wire data_oe,
    input wire irq0,
    input wire irq0_oe,
    input wire irq1_oe
);
    logic cfg_prev_reg;
    logic fifo_prev_reg;
    logic [3:0] cfg_age_reg;
    logic [3:0] fifo_age_reg;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ========================================
    // Cycles since each select pin rose, saturating
    always @(posedge ref_clk)
    begin
        cfg_prev_reg <= cfg_port_select_n;
        fifo_prev_reg <= fifo_port_select_n;
        if (rst || (cfg_port_select_n && !cfg_prev_reg))
            cfg_age_reg <= {4{rst}};
        else if (cfg_age_reg != 4'hf)
            cfg_age_reg <= cfg_age_reg + 4'h1;
        if (rst || (fifo_port_select_n && !fifo_prev_reg))
            fifo_age_reg <= {4{rst}};
        else if (fifo_age_reg != 4'hf)
            fifo_age_reg <= fifo_age_reg + 4'h1;
    end
    idle_release_a: assert property (
        (cfg_port_select_n && fifo_port_select_n) [*8] |-> !miso_oe)
        else $error("miso driven with no port selected");
    cfg_drive_a: assert property (
        (!cfg_port_select_n) [*8] |-> miso_oe)
        else $error("miso released while config selected");
    data_drive_a: assert property (
        $fell(fifo_port_select_n) && cfg_port_select_n |-> ##[2:7] miso_oe)
        else $error("miso not driven after data select");
    cfg_release_a: assert property (
        $rose(cfg_port_select_n) && fifo_port_select_n |-> ##[2:8] !miso_oe)
        else $error("miso still driven after deselect");
    irq_pair_a: assert property (irq0_oe == irq1_oe)
        else $error("interrupt pin enables differ");
    mode_commit_a: assert property (
        $changed(irq0_oe) && !$past(rst) && !$past(rst, 2)
        |-> cfg_age_reg inside {[4'h2:4'hb]})
        else $error("pin enable changed away from config rise");
    rx_commit_a: assert property (
        $changed(data_oe) && !$past(rst) |-> cfg_age_reg inside {[4'h2:4'hb]})
        else $error("data pin enable changed away from config rise");
    push_time_a: assert property (
        $rose(irq0) && !data_oe |-> fifo_age_reg inside {[4'h2:4'hb]})
        else $error("fifo filled away from data select rise");
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the dual slave SPI FIFO datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic demod_bit = 1'b0;
    logic data_in = 1'b0;
    wire sck, mosi, cfg_port_select_n, fifo_port_select_n;
    wire miso, miso_oe, data_out, data_oe, mod_bit;
    wire irq0, irq0_oe, irq1, irq1_oe;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] v;
    logic [46:0] got;
    logic [47:0] tx_frame = 48'h555555_69a53c;
    logic [23:0] rx_frame = 24'h5569c3;
    logic [7:0] mt [5] = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h46};
    logic oe [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    always #25 ref_clk = !ref_clk;
    dual_slave_spi_fifo_datapath #(.BIT_DIV(8)) uut (
        .ref_clk(ref_clk),
        .rst(rst),
        .sck(sck),
        .mosi(mosi),
        .cfg_port_select_n(cfg_port_select_n),
        .fifo_port_select_n(fifo_port_select_n),
        .miso(miso),
        .miso_oe(miso_oe),
        .data_in(data_in),
        .data_out(data_out),
        .data_oe(data_oe),
        .irq0(irq0),
        .irq0_oe(irq0_oe),
        .irq1(irq1),
        .irq1_oe(irq1_oe),
        .demod_bit(demod_bit),
        .mod_bit(mod_bit)
    );
    // Released miso pin is pulled up
    wire miso_pin = miso_oe ? miso : 1'b1;
    spi_master_model m (
        .ref_clk(ref_clk),
        .sck(sck),
        .mosi(mosi),
        .cfg_port_select_n(cfg_port_select_n),
        .fifo_port_select_n(fifo_port_select_n),
        .miso(miso_pin)
    );
    // ========================================
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        m.sel_on(2'b10);
        m.xfer(a, v);
        m.xfer(d, v);
        m.close;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        m.sel_on(2'b10);
        m.xfer({1'b1, a[6:0]}, v);
        m.xfer(8'h00, v);
        m.close;
        chk(v, exp);
    endtask
    task push(input logic [7:0] d);
        m.sel_on(2'b01);
        m.xfer(d, v);
        m.close;
    endtask
    task pop(input logic [7:0] exp);
        m.sel_on(2'b01);
        m.xfer(8'h00, v);
        m.close;
        chk(v, exp);
    endtask
    // Sample the modulator bits from the first rising edge on
    task automatic grab;
        int n = 0;
        while (mod_bit !== 1'b1 && n < 3000)
        begin
            @(negedge ref_clk);
            n++;
        end
        repeat (4) @(negedge ref_clk);
        for (int i = 46; i >= 0; i--)
        begin
            got[i] = mod_bit;
            repeat (8) @(negedge ref_clk);
        end
    endtask
    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        rd(8'h00, 8'h2e);
        rd(8'h02, 8'h69);
        rd(8'h01, 8'h00);
        m.sel_on(2'b11);
        m.xfer(8'h82, v);
        m.xfer(8'h00, v);
        chk(v, 8'h69);
        m.xfer(8'h80, v);
        m.xfer(8'h00, v);
        chk(v, 8'h2e);
        m.close;
        m.sel_on(2'b10);
        m.xfer(8'h03, v);
        m.xfer(8'h5a, v);
        m.xfer(8'h00, v);
        m.xfer(8'h0e, v);
        repeat (8) @(negedge ref_clk);
        chk(irq0_oe, 1'b1);
        m.close;
        chk(irq0_oe, 1'b0);
        rd(8'h03, 8'h5a);
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h00, mt[i]);
            chk(irq1_oe, oe[i]);
        end
        wr(8'h00, 8'h28);
        for (int i = 0; i < 16; i++)
        begin
            push(8'(i));
            chk(irq1, i == 15);
        end
        chk(irq0, 1'b1);
        push(8'hff);
        rd(8'h01, 8'h07);
        wr(8'h01, 8'h01);
        rd(8'h01, 8'h00);
        wr(8'h00, 8'h30);
        push(8'ha5);
        push(8'h3c);
        fork
            wr(8'h00, 8'h90);
            grab;
        join
        for (int k = 0; k < 6; k++)
            chk(8'({1'b0, got} >> 8 * k), 8'(tx_frame >> 8 * k));
        wr(8'h00, 8'h70);
        for (int i = 23; i >= 0; i--)
        begin
            demod_bit = rx_frame[i];
            repeat (8) @(negedge ref_clk);
        end
        demod_bit = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(irq0, 1'b1);
        pop(8'hc3);
        wr(8'h00, 8'h30);
        wr(8'h01, 8'h01);
        pop(8'h00);
        rd(8'h01, 8'h00);
        wr(8'h00, 8'h66);
        demod_bit = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(data_out, 1'b1);
        chk(data_oe, 1'b1);
        wr(8'h00, 8'h86);
        data_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk(mod_bit, 1'b1);
        chk(data_oe, 1'b0);
        data_in = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk(mod_bit, 1'b0);
        give_verdict;
    end
    initial
    begin
        repeat (40000) @(negedge ref_clk);
        n_errors++;
        give_verdict;
    end
endmodule
bind dual_slave_spi_fifo_datapath dual_slave_spi_fifo_datapath_sva sva_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg_port_select_n(cfg_port_select_n),
    .fifo_port_select_n(fifo_port_select_n),
    .miso_oe(miso_oe),
    .data_oe(data_oe),
    .irq0(irq0),
    .irq0_oe(irq0_oe),
    .irq1_oe(irq1_oe)
);
`default_nettype wire
